// *** lscs_pkg.sv ***
// package for the led sink current select register group
// assumes ahb-lite slave with 32-bit data, word per register
package lscs_pkg;
    localparam int          NUM_PORTS       = 10;
    localparam int          LOW_PORTS       = 8;
    localparam int          HIGH_PORTS      = 2;
    localparam int          LEVEL_W         = 3;
    // printed offsets are not all multiples of four: kept as indices
    localparam logic [7:0]  IDX_SEL_LOW     = 8'h13;
    localparam logic [7:0]  IDX_SEL_HIGH    = 8'h14;
    localparam logic [7:0]  IDX_GLOBAL      = 8'h15;
    localparam logic [7:0]  RST_SEL_LOW     = 8'h00;
    localparam logic [1:0]  RST_SEL_HIGH    = 2'h0;
    localparam logic [2:0]  RST_GLOBAL      = 3'h7;
    // current unit: one step of half current in units of 1.25 ma
    localparam int          CODE_W          = 5;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        valid;
    } lscs_req_s;
endpackage

// *** lscs_code.sv ***
// per-port current code: full or half of the global level
// assumes the level and select change synchronously to clk
`timescale 1ns/1ns
`default_nettype none
module lscs_code
    import lscs_pkg::*;
(
    input  wire logic [LEVEL_W-1:0] level_i,
    input  wire logic               full_i,
    output logic      [CODE_W-1:0]  code_o
);
    // code in 1.25 ma units: full = 2*(level+1), half = level+1
    logic [CODE_W-1:0] steps;
    always_comb begin
        steps  = CODE_W'(level_i) + CODE_W'(1);
        code_o = full_i ? CODE_W'(steps << 1) : steps;
    end
endmodule
`default_nettype wire

// *** lscs_top.sv ***
// register group and per-port sink current codes, ahb-lite slave
// assumes single word transfers; zero-wait, always okay
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Contract
// RULE1 - each port sinks half or full global current from its own bit.
// RULE2 - index 0x13 holds select bits for ports 0..7, 1 meaning full.
// RULE3 - index 0x14 bits 1:0 hold ports 8,9; upper bits ignored, read 0.
// RULE4 - index 0x15 bits 2:0 hold the global level; 7:3 ignored, read 0.
// RULE5 - full current is 2.5 ma times code plus one, half is its half.
// RULE6 - after reset the global level is 111, 20 ma full, 10 ma half.
// RULE7 - a select change reaches an active output with nothing else.
module lscs_top
    import lscs_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic      [31:0]            hrdata_o,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    output logic      [NUM_PORTS-1:0]   port_full_o,
    output logic      [LEVEL_W-1:0]     global_level_o,
    output logic [NUM_PORTS*CODE_W-1:0] port_code_o
);

    // request taken in the address phase, used in the data phase
    lscs_req_s                req_q;
    lscs_req_s                req_d;
    logic                     take_addr;
    logic                     rd_now;
    logic                     wr_any;
    logic                     wr_low;
    logic                     wr_high;
    logic                     wr_level;

    // register state and the read word
    logic [LOW_PORTS-1:0]     low_sel_q;
    logic [LOW_PORTS-1:0]     low_sel_d;
    logic [HIGH_PORTS-1:0]    high_sel_q;
    logic [HIGH_PORTS-1:0]    high_sel_d;
    logic [LEVEL_W-1:0]       level_q;
    logic [LEVEL_W-1:0]       level_d;
    logic [31:0]              rdata_q;
    logic [31:0]              rdata_d;

    // word index; upper address bits alias onto the same words
    function automatic logic [7:0] reg_index(
        input logic [31:0] a
    );
        reg_index = a[9:2];
    endfunction

    // one decode shared by the write strobes and the read mux
    function automatic logic hits(
        input logic [31:0] a,
        input logic [7:0]  idx
    );
        hits = (reg_index(a) == idx);
    endfunction

    // unmapped words and unused bits read as zero
    function automatic logic [31:0] read_word(
        input logic [31:0]           a,
        input logic [LOW_PORTS-1:0]  low,
        input logic [HIGH_PORTS-1:0] high,
        input logic [LEVEL_W-1:0]    level
    );
        if (hits(a, IDX_SEL_LOW)) begin
            read_word = {24'h00_0000, low}; // RULE2
        end else if (hits(a, IDX_SEL_HIGH)) begin
            read_word = {30'h0000_0000, high}; // RULE3
        end else if (hits(a, IDX_GLOBAL)) begin
            read_word = {29'h0000_0000, level}; // RULE4
        end else begin
            read_word = 32'h0000_0000;
        end
    endfunction

    // bus decode: address phase taken, write strobes per register
    // hready is the bus's own, looped back from hreadyout
    always_comb begin
        take_addr = 1'b0;
        rd_now    = 1'b0;
        wr_any    = 1'b0;
        wr_low    = 1'b0;
        wr_high   = 1'b0;
        wr_level  = 1'b0;
        if (hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ)) begin
            take_addr = 1'b1;
            rd_now    = !hwrite_i;
        end
        // a write lands only as its data phase completes
        if (req_q.valid && req_q.write && hready_i) begin
            wr_any = 1'b1;
        end
        // unmapped words fall through, so their writes are lost
        if (wr_any) begin
            if (hits(req_q.addr, IDX_SEL_LOW)) begin
                wr_low = 1'b1;
            end else if (hits(req_q.addr, IDX_SEL_HIGH)) begin
                wr_high = 1'b1;
            end else if (hits(req_q.addr, IDX_GLOBAL)) begin
                wr_level = 1'b1;
            end
        end
    end

    // request group; reset drops a transfer in flight
    always_comb begin
        req_d = '0;
        if (rst_i) begin
            req_d = '0;
        end else if (!hready_i) begin
            // data phase stretched: keep the pending request
            req_d = req_q;
        end else if (take_addr) begin
            req_d.addr  = haddr_i;
            req_d.write = hwrite_i;
            req_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        req_q <= req_d;
    end

    // low select group; reset leaves every port at half current
    // bit n of the word drives port n
    always_comb begin
        low_sel_d = low_sel_q;
        if (rst_i) begin
            low_sel_d = RST_SEL_LOW;
        end else if (wr_low) begin
            low_sel_d = hwdata_i[LOW_PORTS-1:0]; // RULE2
        end
    end

    always_ff @(posedge clk_sys_i) begin
        low_sel_q <= low_sel_d;
    end

    // high select group; bits 7:2 of the word are dropped here
    always_comb begin
        high_sel_d = high_sel_q;
        if (rst_i) begin
            high_sel_d = RST_SEL_HIGH;
        end else if (wr_high) begin
            high_sel_d = hwdata_i[HIGH_PORTS-1:0]; // RULE3
        end
    end

    always_ff @(posedge clk_sys_i) begin
        high_sel_q <= high_sel_d;
    end

    // global level group; bits 7:3 of the word are dropped here
    // a level of zero still leaves the lowest nonzero current
    always_comb begin
        level_d = level_q;
        if (rst_i) begin
            level_d = RST_GLOBAL; // RULE6
        end else if (wr_level) begin
            level_d = hwdata_i[LEVEL_W-1:0]; // RULE4
        end
    end

    always_ff @(posedge clk_sys_i) begin
        level_q <= level_d;
    end

    // read word registered in the address phase to stand in the data
    // phase; next values keep a write followed by a read coherent
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rst_i) begin
            rdata_d = 32'h0000_0000;
        end else if (!hready_i) begin
            // held while the data phase is stretched
            rdata_d = rdata_q;
        end else if (rd_now) begin
            rdata_d = read_word(haddr_i,
                                low_sel_d,
                                high_sel_d,
                                level_d); // RULE2 RULE3 RULE4
        end
    end

    always_ff @(posedge clk_sys_i) begin
        rdata_q <= rdata_d;
    end

    // zero wait states, so no error path is ever needed
    assign hreadyout_o    = 1'b1;
    assign hresp_o        = 1'b0;
    assign hrdata_o       = rdata_q;
    // hsize is not checked: every register is one whole word

    // straight from the registers so a select change acts at once
    assign port_full_o    = {high_sel_q, low_sel_q}; // RULE7
    assign global_level_o = level_q;

    // codes are plain decodes of flops: no path from the bus pins
    // one decoder per port, so every sink sees the same delay
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            lscs_code u_code (
                .level_i (level_q),
                .full_i  (port_full_o[g]),
                .code_o  (port_code_o[g*CODE_W +: CODE_W])
            ); // RULE1 RULE5
        end
    endgenerate
endmodule
`default_nettype wire

// *** lscs_chk_asserts.sv ***
// checker for lscs_top: register and current code relations
// assumes zero-wait ahb-lite, hready looped from hreadyout
`timescale 1ns/1ns
`default_nettype none
module lscs_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [1:0]  htrans_i,
    input wire logic [31:0] haddr_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic [9:0]  port_full_o,
    input wire logic [2:0]  global_level_o,
    input wire logic [49:0] port_code_o
);
logic w_q,r_q; logic [7:0] a_q; wire logic [4:0] l1={2'h0,global_level_o}+5'h1;
// data phase tracker; selected requests with hready and htrans bit 1 set, seq as well as nonseq
always_ff @(posedge clk_sys_i) begin
 w_q<=hsel_i&hready_i&htrans_i[1]&!rst_i&hwrite_i;
 r_q<=hsel_i&hready_i&htrans_i[1]&!rst_i&!hwrite_i;
 a_q<=haddr_i[7:0];
end
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
property p_r1; port_code_o[49:45]==l1<<port_full_o[9]; endproperty
a_r1: assert property(p_r1) else $error("port 9 code");
property p_r2; w_q&&a_q==8'h4C|=>port_full_o[7:0]==$past(hwdata_i[7:0]);
endproperty
a_r2: assert property(p_r2) else $error("low selects");
property p_r3; r_q&&a_q==8'h50|->hrdata_o=={30'h0,port_full_o[9:8]};
endproperty
a_r3: assert property(p_r3) else $error("high selects");
property p_r4; r_q&&a_q==8'h54|->hrdata_o=={29'h0,global_level_o};
endproperty
a_r4: assert property(p_r4) else $error("level read");
property p_r5; port_code_o[4:0]==l1<<port_full_o[0]; endproperty
a_r5: assert property(p_r5) else $error("port 0 code");
property p_r6; $fell(rst_i)|->global_level_o==3'h7; endproperty
a_r6: assert property(p_r6) else $error("reset level");
property p_r7; $changed(port_full_o[0])&&$stable(global_level_o)
 |->$changed(port_code_o[4:0]); endproperty
a_r7: assert property(p_r7) else $error("select lag");
endmodule
bind lscs_top lscs_chk u_lscs_chk (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .hsel_i         (hsel_i),
    .hwrite_i       (hwrite_i),
    .hready_i       (hready_i),
    .htrans_i       (htrans_i),
    .haddr_i        (haddr_i),
    .hwdata_i       (hwdata_i),
    .hrdata_o       (hrdata_o),
    .port_full_o    (port_full_o),
    .global_level_o (global_level_o),
    .port_code_o    (port_code_o)
);
`default_nettype wire

// *** lscs_sink.sv ***
// sink model: port 0 current code to microamps
// assumes 1.25 ma per code step
`timescale 1ns/1ns
`default_nettype none
module lscs_sink (
    input  wire logic [4:0]  code_i,
    output logic      [15:0] ua_o
);
assign ua_o=16'(code_i)*16'h04E2;
endmodule
`default_nettype wire

// *** led_sink_current_select_tb_top.sv ***
// testbench: ahb-lite register access and current code checks
// assumes zero-wait slave, single word transfers
`timescale 1ns/1ns
`default_nettype none
module led_sink_current_select_tb_top;
import lscs_pkg::*;
logic clk_sys_i=0,rst_i=1,hsel_i=0,hwrite_i=0; logic [1:0] htrans_i=2'h0;
logic [2:0] hsize_i=HSIZE_WORD; logic [31:0] haddr_i=32'h0,hwdata_i=32'h0,r;
wire logic hready_i,hreadyout_o,hresp_o; wire logic [31:0] hrdata_o;
wire logic [9:0] port_full_o; wire logic [2:0] global_level_o;
wire logic [49:0] port_code_o; wire logic [15:0] ua;
int bad_count=0,samples_checked=0;
assign hready_i=hreadyout_o;
lscs_top u_lscs_top(.*);
lscs_sink u_lscs_sink(.code_i(port_code_o[4:0]),.ua_o(ua));
initial forever #10 clk_sys_i=~clk_sys_i;
task automatic ck(input logic [31:0] g,e);
 samples_checked++;
 if (g!==e) begin bad_count++; $display("FAIL %0t %h %h",$time,g,e); end
endtask
task automatic xf(input logic w,input logic [31:0] a,d);
 hsel_i<=1'b1; htrans_i<=HTRANS_NONSEQ; haddr_i<=a; hwrite_i<=w;
 do @(posedge clk_sys_i); while (hready_i!==1'b1);
 hsel_i<=1'b0; htrans_i<=2'h0; hwdata_i<=d;
 do @(posedge clk_sys_i); while (hready_i!==1'b1);
 r=hrdata_o;
 ck(32'(hresp_o),32'h0);
endtask
task summarize;
 $display("checked %0d bad %0d",samples_checked,bad_count);
 if (bad_count==0&&samples_checked>0) $display("STATUS OK");
 else $display("STATUS NOT OK");
 $finish;
endtask
// run needs about 1.5 us; limit leaves wide margin
initial begin #100000 bad_count++; summarize; end
initial begin
 repeat (20) @(posedge clk_sys_i); rst_i<=1'b0;
 xf(0,32'h54,0); ck(r,32'h7);
 ck(32'(port_code_o[49:45]),32'h8);
 $display("reset done");
 xf(1,32'h4C,32'hFFFFFFA5); xf(0,32'h4C,0); ck(r,32'hA5);
 ck(32'(port_full_o),32'hA5);
 xf(1,32'h50,32'hFFFFFFFE); xf(0,32'h50,0); ck(r,32'h2);
 xf(1,32'h58,32'hFF); xf(0,32'h58,0); ck(r,32'h0);
 $display("selects done");
 for (int i=0;i<8;i++) begin
  xf(1,32'h54,{29'h1FFFFFFF,3'(i)}); xf(0,32'h54,0); ck(r,i);
  ck(32'(ua),32'h9C4*(i+1));
  ck(32'(port_code_o[9:5]),i+1);
  ck(32'(global_level_o),i);
  for (int p=0;p<10;p++)
   ck(32'(port_code_o[p*5+:5]),((32'h2A5>>p)&1)?2*(i+1):i+1);
 end
 $display("levels done");
 xf(1,32'h4C,32'h5A); xf(0,32'h4C,0); ck(r,32'h5A);
 ck(32'(ua),32'h2710);
 ck(32'(port_code_o[9:5]),32'h10);
 $display("select switch done");
 xf(1,32'h54,32'h2);
 rst_i<=1'b1; repeat (3) @(posedge clk_sys_i); rst_i<=1'b0;
 xf(0,32'h54,0); ck(r,32'h7);
 ck(32'(port_full_o),32'h0);
 ck(32'(ua),32'h2710);
 $display("second reset done");
 summarize;
end
endmodule
`default_nettype wire
